/* common/uart_ctl_pkg.sv */
// constants for the serial status and control block
package uart_ctl_pkg;
    // register indices (word addresses on the plain port)
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_TXDATA = 4'h1;
    localparam logic [3:0] ADDR_RXDATA = 4'h2;
    localparam logic [3:0] ADDR_IRQ_STAT = 4'h3;
    localparam logic [3:0] ADDR_IRQ_MASK = 4'h4;
    // control register field positions
    localparam int BIT_TXSEL_HI = 15;
    localparam int BIT_TXINV = 14;
    localparam int BIT_TXSEL_LO = 13;
    localparam int BIT_BRK = 11;
    localparam int BIT_TXEN = 10;
    localparam int BIT_TXBF = 9;
    localparam int BIT_TX_SHIFT_EMPTY_FLAG = 8;
    localparam int BIT_RXSEL_HI = 7;
    localparam int BIT_RXSEL_LO = 6;
    localparam int BIT_RXDA = 0;
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    // interrupt status bit positions
    localparam int IRQ_TX = 0;
    localparam int IRQ_RX = 1;
    // transmit interrupt selection codes
    localparam logic [1:0] TXSEL_EACH = 2'h0;
    localparam logic [1:0] TXSEL_DONE = 2'h1;
    localparam logic [1:0] TXSEL_EMPTY = 2'h2;
    // receive interrupt selection codes
    localparam logic [1:0] RXSEL_FULL = 2'h3;
    localparam logic [1:0] RXSEL_3Q = 2'h2;
    // frame shape
    localparam logic [3:0] DATA_BITS = 4'h8;
    localparam logic [3:0] BREAK_BITS = 4'hc;
    localparam logic [2:0] RX_DEPTH = 3'h4;
    localparam logic [2:0] RX_3Q = 3'h3;
    // bit time: 16 clocks per bit at 25 MHz
    localparam int CLK_HZ = 25_000_000;
    localparam int BAUD = 1_562_500;
    localparam logic [7:0] BIT_CYC = 8'(CLK_HZ / BAUD);
    localparam logic [7:0] HALF_CYC = 8'(CLK_HZ / BAUD / 2);
    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_START = 2'b01,
        TX_DATA = 2'b11,
        TX_STOP = 2'b10
    } tx_state_t;
endpackage

/* logic/uart_ctl.sv */
// serial port status/control with tx shifter and 4-deep rx buffer
//
// Decided for this implementation: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ns

// Functional notes
// - tx irq select: 10 buffer empties, 01 last char shifted, 00 each transfer.
// - break request sends start, twelve zero bits, then stop on next transmission.
// - hardware clears break request when the break frame has finished.
// - transmit enable high lets the port drive the transmit pin.
// - clearing transmit enable aborts transmission, resets buffer, releases pin.
// - buffer full flag reads one when no more character fits.
// - shift empty flag is one only when shifter and buffer are empty.
// - rx select 11 interrupts when a transfer fills buffer to four.
// - rx select 10 interrupts when a transfer leaves three characters.
// - rx select 0x interrupts on every character moved into the buffer.
module uart_ctl (
    // clock, reset, enable
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic clk_en,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // serial lines
    input wire logic serial_rx_pin,
    output logic serial_tx_pin,
    output logic serial_tx_oe_b,
    // interrupt
    output logic irq
);
    // control bits
    logic [1:0] txsel_r;
    logic txinv_r, brk_r, txen_r;
    logic [1:0] rxsel_r;
    logic [1:0] irq_stat_r, irq_mask_r;
    // transmit path: one holding word plus shifter
    logic [7:0] thr_r, tsr_r;
    logic thr_full_r, brk_frame_r;
    uart_ctl_pkg::tx_state_t tx_st_r;
    logic [7:0] tx_cnt_r;
    logic [3:0] tx_bit_r;
    logic tx_line_r;
    // receive path
    logic [7:0] rx_mem [0:3];
    logic [1:0] rx_wp_r, rx_rp_r;
    logic [2:0] rx_lvl_r;
    logic rx_busy_r;
    logic [7:0] rx_cnt_r, rx_sh_r;
    logic [3:0] rx_bit_r;
    logic [15:0] rdata_r;
    logic tx_pin_r, tx_oe_b_r, irq_r;

    // address decode
    wire wr_ctrl = reg_wr && reg_addr == uart_ctl_pkg::ADDR_CTRL;
    wire wr_tx = reg_wr && reg_addr == uart_ctl_pkg::ADDR_TXDATA;
    wire rd_rx = reg_rd && reg_addr == uart_ctl_pkg::ADDR_RXDATA && rx_lvl_r != 3'h0;
    wire wr_stat = reg_wr && reg_addr == uart_ctl_pkg::ADDR_IRQ_STAT;
    wire wr_mask = reg_wr && reg_addr == uart_ctl_pkg::ADDR_IRQ_MASK;
    wire txen_nxt = wr_ctrl ? reg_wdata[uart_ctl_pkg::BIT_TXEN] : txen_r;

    // transmit events
    wire tick_tx = tx_cnt_r == uart_ctl_pkg::BIT_CYC - 8'h01;
    wire load_tsr = txen_r && tx_st_r == uart_ctl_pkg::TX_IDLE && (thr_full_r || brk_r);
    wire stop_done = tx_st_r == uart_ctl_pkg::TX_STOP && tick_tx;
    wire tx_shift_empty = !thr_full_r && tx_st_r == uart_ctl_pkg::TX_IDLE;
    wire brk_done = stop_done && brk_frame_r;
    wire frame_bits_done = tx_bit_r == (brk_frame_r ? uart_ctl_pkg::BREAK_BITS : uart_ctl_pkg::DATA_BITS) - 4'h1;

    // transmit interrupt selection
    wire load_data = load_tsr && !brk_r;
    wire tx_ev = (txsel_r == uart_ctl_pkg::TXSEL_EACH && load_data)
        || (txsel_r == uart_ctl_pkg::TXSEL_EMPTY && load_data)
        || (txsel_r == uart_ctl_pkg::TXSEL_DONE && stop_done && !thr_full_r);

    // receive events: start bit detected, sampled mid-bit
    wire tick_rx = rx_cnt_r == uart_ctl_pkg::BIT_CYC - 8'h01;
    wire rx_push = rx_busy_r && tick_rx && rx_bit_r == 4'h9 && serial_rx_pin && rx_lvl_r != uart_ctl_pkg::RX_DEPTH;
    wire [2:0] lvl_after = rx_lvl_r + 3'h1;
    wire rx_ev = rx_push && (rxsel_r == uart_ctl_pkg::RXSEL_FULL ? lvl_after == uart_ctl_pkg::RX_DEPTH
        : rxsel_r == uart_ctl_pkg::RXSEL_3Q ? lvl_after == uart_ctl_pkg::RX_3Q
        : 1'b1);

    // read mux
    wire [15:0] ctrl_view = {txsel_r[1], txinv_r, txsel_r[0], 1'b0, brk_r, txen_r, thr_full_r, tx_shift_empty,
        rxsel_r, 5'h00, rx_lvl_r != 3'h0};
    wire [15:0] rdata_nxt = reg_addr == uart_ctl_pkg::ADDR_CTRL ? ctrl_view
        : reg_addr == uart_ctl_pkg::ADDR_RXDATA ? {8'h00, rx_mem[rx_rp_r]}
        : reg_addr == uart_ctl_pkg::ADDR_IRQ_STAT ? {14'h0000, irq_stat_r}
        : reg_addr == uart_ctl_pkg::ADDR_IRQ_MASK ? {14'h0000, irq_mask_r} : 16'h0000;
    wire [1:0] stat_nxt = (irq_stat_r & ~(wr_stat ? reg_wdata[1:0] : 2'h0)) | {rx_ev, tx_ev};
    wire line_nxt = (txinv_r ? ~tx_line_r : tx_line_r);

    // control register writes; break bit self-clears
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            {txsel_r, txinv_r, brk_r, txen_r, rxsel_r} <= 7'h00;
        end else if (clk_en) begin
            if (wr_ctrl) begin
                txsel_r <= {reg_wdata[uart_ctl_pkg::BIT_TXSEL_HI], reg_wdata[uart_ctl_pkg::BIT_TXSEL_LO]};
                txinv_r <= reg_wdata[uart_ctl_pkg::BIT_TXINV];
                txen_r <= reg_wdata[uart_ctl_pkg::BIT_TXEN];
                rxsel_r <= reg_wdata[uart_ctl_pkg::BIT_RXSEL_HI:uart_ctl_pkg::BIT_RXSEL_LO];
            end
            if (wr_ctrl && reg_wdata[uart_ctl_pkg::BIT_BRK] && reg_wdata[uart_ctl_pkg::BIT_TXEN]) begin
                brk_r <= 1'b1;
            end else if (brk_done || !txen_nxt) begin
                brk_r <= 1'b0;
            end
        end
    end

    // holding register: abort on disable
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            thr_full_r <= 1'b0;
            thr_r <= 8'h00;
        end else if (clk_en) begin
            if (!txen_nxt) begin
                thr_full_r <= 1'b0;
            end else if (wr_tx && !thr_full_r) begin
                thr_full_r <= 1'b1;
                thr_r <= reg_wdata[7:0];
            end else if (load_data) begin
                thr_full_r <= 1'b0;
            end
        end
    end

    // transmit shifter
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            tx_st_r <= uart_ctl_pkg::TX_IDLE;
            tx_cnt_r <= 8'h00;
            tx_bit_r <= 4'h0;
            tsr_r <= 8'h00;
            brk_frame_r <= 1'b0;
            tx_line_r <= 1'b1;
        end else if (clk_en) begin
            tx_cnt_r <= (tick_tx || tx_st_r == uart_ctl_pkg::TX_IDLE) ? 8'h00 : tx_cnt_r + 8'h01;
            if (!txen_nxt) begin
                tx_st_r <= uart_ctl_pkg::TX_IDLE;
                tx_line_r <= 1'b1;
            end else begin
                unique case (tx_st_r)
                    uart_ctl_pkg::TX_IDLE: if (load_tsr) begin
                        brk_frame_r <= brk_r;
                        tsr_r <= brk_r ? 8'h00 : thr_r;
                        tx_line_r <= 1'b0;
                        tx_st_r <= uart_ctl_pkg::TX_START;
                    end
                    uart_ctl_pkg::TX_START: if (tick_tx) begin
                        tx_bit_r <= 4'h0;
                        tx_line_r <= brk_frame_r ? 1'b0 : tsr_r[0];
                        tx_st_r <= uart_ctl_pkg::TX_DATA;
                    end
                    uart_ctl_pkg::TX_DATA: if (tick_tx) begin
                        if (frame_bits_done) begin
                            tx_line_r <= 1'b1;
                            tx_st_r <= uart_ctl_pkg::TX_STOP;
                        end else begin
                            tx_bit_r <= tx_bit_r + 4'h1;
                            tsr_r <= {1'b0, tsr_r[7:1]};
                            tx_line_r <= brk_frame_r ? 1'b0 : tsr_r[1];
                        end
                    end
                    uart_ctl_pkg::TX_STOP: if (tick_tx) begin
                        tx_st_r <= uart_ctl_pkg::TX_IDLE;
                    end
                endcase
            end
        end
    end

    // receiver: 8N1, start validated at half bit
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rx_busy_r <= 1'b0;
            rx_cnt_r <= 8'h00;
            rx_bit_r <= 4'h0;
            rx_sh_r <= 8'h00;
        end else if (clk_en) begin
            if (!rx_busy_r) begin
                rx_busy_r <= !serial_rx_pin;
                rx_cnt_r <= uart_ctl_pkg::HALF_CYC;
                rx_bit_r <= 4'h0;
            end else begin
                rx_cnt_r <= tick_rx ? 8'h00 : rx_cnt_r + 8'h01;
                if (tick_rx) begin
                    rx_bit_r <= rx_bit_r + 4'h1;
                    if (rx_bit_r == 4'h0 && serial_rx_pin) begin
                        rx_busy_r <= 1'b0; // false start glitch
                    end else if (rx_bit_r == 4'h9) begin
                        rx_busy_r <= 1'b0;
                    end else if (rx_bit_r != 4'h0) begin
                        rx_sh_r <= {serial_rx_pin, rx_sh_r[7:1]};
                    end
                end
            end
        end
    end

    // receive buffer, four characters; overflow drops the new one
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rx_wp_r <= 2'h0;
            rx_rp_r <= 2'h0;
            rx_lvl_r <= 3'h0;
        end else if (clk_en) begin
            if (rx_push) begin
                rx_wp_r <= rx_wp_r + 2'h1;
            end
            if (rd_rx) begin
                rx_rp_r <= rx_rp_r + 2'h1;
            end
            rx_lvl_r <= rx_lvl_r + {2'h0, rx_push} - {2'h0, rd_rx};
        end
    end

    // buffer storage has no reset; level guards reads
    always_ff @(posedge clk_sys) begin
        if (clk_en && rx_push) begin
            rx_mem[rx_wp_r] <= rx_sh_r;
        end
    end

    // interrupt status/mask and registered outputs; set beats clear
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            irq_stat_r <= 2'h0;
            irq_mask_r <= 2'h0;
            rdata_r <= 16'h0000;
            tx_pin_r <= 1'b1;
            tx_oe_b_r <= 1'b1;
            irq_r <= 1'b0;
        end else if (clk_en) begin
            irq_stat_r <= stat_nxt;
            if (wr_mask) begin
                irq_mask_r <= reg_wdata[1:0];
            end
            rdata_r <= reg_rd ? rdata_nxt : 16'h0000;
            tx_pin_r <= line_nxt;
            tx_oe_b_r <= !txen_r;
            irq_r <= |(stat_nxt & (wr_mask ? reg_wdata[1:0] : irq_mask_r));
        end
    end

    assign reg_rdata = rdata_r;
    assign serial_tx_pin = tx_pin_r;
    assign serial_tx_oe_b = tx_oe_b_r;
    assign irq = irq_r;

    // checks
    property p_brk_clear;
        @(posedge clk_sys) disable iff (!rst_b) clk_en && brk_done && !wr_ctrl |=> !brk_r;
    endproperty
    a_brk_clear: assert property (p_brk_clear) else $error("break bit not cleared");
    property p_abort;
        @(posedge clk_sys) disable iff (!rst_b) clk_en && wr_ctrl && !reg_wdata[uart_ctl_pkg::BIT_TXEN]
        |=> !thr_full_r && tx_st_r == uart_ctl_pkg::TX_IDLE;
    endproperty
    a_abort: assert property (p_abort) else $error("disable did not abort");
    property p_oe;
        @(posedge clk_sys) disable iff (!rst_b) clk_en |=> serial_tx_oe_b == !$past(txen_r);
    endproperty
    a_oe: assert property (p_oe) else $error("tx drive mismatch");
    property p_full_wr;
        @(posedge clk_sys) disable iff (!rst_b) clk_en && wr_tx && txen_r && !wr_ctrl |=> thr_full_r;
    endproperty
    a_full_wr: assert property (p_full_wr) else $error("full flag not set");
    property p_tx_shift_empty_flag;
        @(posedge clk_sys) disable iff (!rst_b) clk_en && reg_rd && reg_addr == uart_ctl_pkg::ADDR_CTRL
        |=> reg_rdata[uart_ctl_pkg::BIT_TX_SHIFT_EMPTY_FLAG] == ($past(tx_st_r) == uart_ctl_pkg::TX_IDLE && !$past(thr_full_r));
    endproperty
    a_tx_shift_empty_flag: assert property (p_tx_shift_empty_flag) else $error("shift empty wrong");
    property p_rx_full;
        @(posedge clk_sys) disable iff (!rst_b) clk_en && rx_push && rxsel_r == uart_ctl_pkg::RXSEL_FULL
        && rx_lvl_r == 3'h3 |=> irq_stat_r[uart_ctl_pkg::IRQ_RX];
    endproperty
    a_rx_full: assert property (p_rx_full) else $error("full rx irq missed");
    property p_rx_3q;
        @(posedge clk_sys) disable iff (!rst_b) clk_en && rx_push && rxsel_r == uart_ctl_pkg::RXSEL_3Q
        && rx_lvl_r == 3'h2 |=> irq_stat_r[uart_ctl_pkg::IRQ_RX];
    endproperty
    a_rx_3q: assert property (p_rx_3q) else $error("3/4 rx irq wrong");
    property p_rx_any;
        @(posedge clk_sys) disable iff (!rst_b) clk_en && rx_push && !rxsel_r[1] |=> irq_stat_r[1];
    endproperty
    a_rx_any: assert property (p_rx_any) else $error("rx irq missed");
    property p_brk_line;
        @(posedge clk_sys) disable iff (!rst_b) tx_st_r == uart_ctl_pkg::TX_DATA && brk_frame_r |-> !tx_line_r;
    endproperty
    a_brk_line: assert property (p_brk_line) else $error("break bit not zero");
    property p_inv;
        @(posedge clk_sys) disable iff (!rst_b) clk_en |=> serial_tx_pin == ($past(txinv_r) ^ $past(tx_line_r));
    endproperty
    a_inv: assert property (p_inv) else $error("polarity wrong");
    c_tx_done: cover property (@(posedge clk_sys) disable iff (!rst_b) stop_done && txsel_r == 2'h1);
    c_brk: cover property (@(posedge clk_sys) disable iff (!rst_b) brk_done);
    c_rx_full: cover property (@(posedge clk_sys) disable iff (!rst_b) rx_lvl_r == 3'h4);
endmodule

/* dv/serial_peer.sv */
// far-side serial transceiver model: drives the receive line, decodes the transmit line
`timescale 1ns/1ns
module serial_peer (
    // clock
    input wire logic clk_sys,
    // lines
    input wire logic line_in,
    output logic line_out,
    // last decoded frame
    output logic [7:0] frames,
    output logic [7:0] last_data,
    output logic [3:0] last_run
);
    logic s;
    logic [7:0] data;
    logic [3:0] run;
    int i;

    // start frame lsb first, stop bit high, line idles high afterwards
    task automatic send_byte(input logic [7:0] d);
        logic [9:0] f;
        f = {1'b1, d, 1'b0};
        for (int k = 0; k < 10; k++) begin
            line_out <= f[k];
            repeat (uart_ctl_pkg::BIT_CYC) @(posedge clk_sys);
        end
    endtask

    // decoder counts low bit times from the start bit, so a break shows as a long run
    initial begin
        line_out = 1'b1;
        frames = 8'h00;
        last_data = 8'h00;
        last_run = 4'h0;
        forever begin
            @(posedge clk_sys);
            if (line_in === 1'b0) begin
                repeat (uart_ctl_pkg::HALF_CYC) @(posedge clk_sys);
                // short glitches (polarity switch) are not starts
                if (line_in === 1'b0) begin
                    run = 4'h1;
                    i = 0;
                    s = 1'b0;
                    while (!(s === 1'b1 && i >= 9) && i < 15) begin
                        repeat (uart_ctl_pkg::BIT_CYC) @(posedge clk_sys);
                        i++;
                        s = line_in;
                        if (i <= 8) data[i-1] = s;
                        if (s === 1'b0 && run == 4'(i)) run++;
                    end
                    last_data <= data;
                    last_run <= run;
                    frames <= frames + 8'h01;
                end
            end
        end
    end
endmodule

/* dv/tb_uart_tx_rx_status_control.sv */
// self-checking bench for the serial status and control block
`timescale 1ns/1ns
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin errors++; \
    $display("mismatch at %0t: got %h expected %h", $time, (a), (e)); end end
module tb_uart_tx_rx_status_control;
    logic clk_sys;
    logic rst_b;
    logic clk_en;
    logic [3:0] reg_addr;
    logic [15:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [15:0] reg_rdata;
    logic serial_rx_pin;
    logic serial_tx_pin;
    logic serial_tx_oe_b;
    logic irq;
    logic inv_on;
    logic [15:0] v;
    logic [7:0] frames;
    logic [7:0] last_data;
    logic [3:0] last_run;
    logic [7:0] f;
    int errors = 0;
    int comparisons = 0;
    int cycles = 0;
    // released pin is pulled high; the peer sees the line with inversion undone
    wire tx_line = serial_tx_oe_b ? 1'b1 : (serial_tx_pin ^ inv_on);

    uart_ctl DUT (.clk_sys(clk_sys), .rst_b(rst_b), .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .serial_rx_pin(serial_rx_pin),
        .serial_tx_pin(serial_tx_pin), .serial_tx_oe_b(serial_tx_oe_b), .irq(irq));
    serial_peer peer (.clk_sys(clk_sys), .line_in(tx_line), .line_out(serial_rx_pin), .frames(frames),
        .last_data(last_data), .last_run(last_run));

    task automatic final_report();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask

    // read data taken at the edge after the strobe, the only cycle it stands
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(posedge clk_sys);
        d = reg_rdata;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task automatic wait_frame();
        logic [7:0] f0;
        f0 = frames;
        for (int k = 0; k < 400 && frames === f0; k++) @(posedge clk_sys);
        `CHK(frames !== f0, 1'b1)
    endtask

    task automatic wait_empty();
        logic [15:0] r;
        r = 16'h0000;
        for (int k = 0; k < 300 && r[8] !== 1'b1; k++) rd(uart_ctl_pkg::ADDR_CTRL, r);
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    // hang guard: whole run is a few thousand cycles
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors++;
            final_report();
        end
    end

    initial begin
        rst_b = 1'b0;
        clk_en = 1'b1;
        reg_addr = 4'h0;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        inv_on = 1'b0;
        tick(2);
        `CHK({serial_tx_oe_b, irq}, 2'b10)
        rst_b <= 1'b1;
        rd(uart_ctl_pkg::ADDR_CTRL, v);
        `CHK(v[15:8], 8'h01)
        `CHK(v[0], 1'b0)
        wr(4'hf, 16'hffff);
        rd(4'hf, v);
        `CHK(v, 16'h0000)
        // a write while the enable is low must leave all state frozen
        clk_en <= 1'b0;
        wr(uart_ctl_pkg::ADDR_IRQ_MASK, 16'h0003);
        clk_en <= 1'b1;
        rd(uart_ctl_pkg::ADDR_IRQ_MASK, v);
        `CHK(v, 16'h0000)
        // two chars back to back, third refused while buffer full
        wr(uart_ctl_pkg::ADDR_CTRL, 16'h0400);
        tick(2);
        `CHK(serial_tx_oe_b, 1'b0)
        wr(uart_ctl_pkg::ADDR_TXDATA, 16'h00a5);
        wr(uart_ctl_pkg::ADDR_TXDATA, 16'h003c);
        wr(uart_ctl_pkg::ADDR_TXDATA, 16'h0077);
        rd(uart_ctl_pkg::ADDR_CTRL, v);
        `CHK(v[9:8], 2'b10)
        wait_frame();
        `CHK({last_data, last_run}, 12'ha51)
        wait_frame();
        `CHK({last_data, last_run}, 12'h3c3)
        f = frames;
        tick(200);
        `CHK(frames, f)
        rd(uart_ctl_pkg::ADDR_CTRL, v);
        `CHK(v[9:8], 2'b01)
        // transmit interrupt codes: only the done code waits for the shift to finish
        wr(uart_ctl_pkg::ADDR_IRQ_MASK, 16'h0001);
        for (int c = 0; c < 3; c++) begin
            wr(uart_ctl_pkg::ADDR_CTRL, 16'h0400 | (16'(c[1]) << 15) | (16'(c[0]) << 13));
            wr(uart_ctl_pkg::ADDR_IRQ_STAT, 16'h0003);
            wr(uart_ctl_pkg::ADDR_TXDATA, 16'h0055);
            tick(6);
            `CHK(irq, (c != 1))
            wait_frame();
            tick(20);
            `CHK(irq, 1'b1)
        end
        wr(uart_ctl_pkg::ADDR_IRQ_MASK, 16'h0000);
        tick(2);
        `CHK(irq, 1'b0)
        rd(uart_ctl_pkg::ADDR_IRQ_STAT, v);
        `CHK(v[0], 1'b1)
        wr(uart_ctl_pkg::ADDR_IRQ_STAT, 16'h0001);
        rd(uart_ctl_pkg::ADDR_IRQ_STAT, v);
        `CHK(v[0], 1'b0)
        // sync break, request bit self-clears afterwards
        wr(uart_ctl_pkg::ADDR_CTRL, 16'h0c00);
        rd(uart_ctl_pkg::ADDR_CTRL, v);
        `CHK(v[11], 1'b1)
        wr(uart_ctl_pkg::ADDR_TXDATA, 16'h00ff);
        wait_frame();
        `CHK(last_run, 4'hd)
        wait_empty();
        rd(uart_ctl_pkg::ADDR_CTRL, v);
        `CHK(v[11:8], 4'h5)
        // inverted polarity, idle level included
        wr(uart_ctl_pkg::ADDR_CTRL, 16'h4400);
        inv_on = 1'b1;
        tick(3);
        `CHK(serial_tx_pin, 1'b0)
        wr(uart_ctl_pkg::ADDR_TXDATA, 16'h0096);
        wait_frame();
        `CHK(last_data, 8'h96)
        wait_empty();
        wr(uart_ctl_pkg::ADDR_CTRL, 16'h0400);
        inv_on = 1'b0;
        // abort in mid frame with a char queued
        wr(uart_ctl_pkg::ADDR_TXDATA, 16'h0000);
        wr(uart_ctl_pkg::ADDR_TXDATA, 16'h0011);
        tick(10);
        wr(uart_ctl_pkg::ADDR_CTRL, 16'h0000);
        tick(2);
        `CHK(serial_tx_oe_b, 1'b1)
        rd(uart_ctl_pkg::ADDR_CTRL, v);
        `CHK(v[9:8], 2'b01)
        tick(200);
        f = frames;
        wr(uart_ctl_pkg::ADDR_CTRL, 16'h0400);
        tick(200);
        `CHK(frames, f)
        // receive thresholds for each selection code
        wr(uart_ctl_pkg::ADDR_IRQ_MASK, 16'h0002);
        for (int c = 0; c < 4; c++) begin
            wr(uart_ctl_pkg::ADDR_CTRL, 16'(c) << 6);
            wr(uart_ctl_pkg::ADDR_IRQ_STAT, 16'h0003);
            for (int n = 1; n <= 4; n++) begin
                peer.send_byte(8'(16 * c + n));
                tick(24);
                `CHK(irq, (n >= (c < 2 ? 1 : c + 1)))
            end
            for (int n = 1; n <= 4; n++) begin
                rd(uart_ctl_pkg::ADDR_RXDATA, v);
                `CHK(v[7:0], 8'(16 * c + n))
            end
            rd(uart_ctl_pkg::ADDR_CTRL, v);
            `CHK(v[0], 1'b0)
            wr(uart_ctl_pkg::ADDR_IRQ_STAT, 16'h0002);
            tick(2);
            `CHK(irq, 1'b0)
        end
        final_report();
    end
endmodule
